//--- dcp_regs.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module dcp_regs
  import dcp_pkg::*;
#(
  parameter int CHANNELS = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire dcp_bus_s    bus,
  output logic [7:0]       rdata,
  output logic [15:0]      dac_clear,
  output logic [15:0]      dac_active,
  output logic [15:0]      dac_clamp
);

  //------------------------------------------------------------
  // elaboration checks
  //------------------------------------------------------------
  if (CHANNELS != 16) begin : g_bad_channels
    $error("dcp_regs supports exactly sixteen channels");
  end

  dcp_state_s state_r;
  dcp_state_s state_nxt;

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  // register writes, readback, and per-channel controls
  always_comb begin
    state_nxt = state_r;
    if (bus.wr) begin
      unique case (bus.addr)
        DCP_CLR_LO_OFS: state_nxt.clr_lo = bus.wdata;
        DCP_CLR_HI_OFS: state_nxt.clr_hi = bus.wdata;
        DCP_PWR_LO_OFS: state_nxt.pwr_lo = bus.wdata;
        DCP_PWR_HI_OFS: state_nxt.pwr_hi = bus.wdata;
        default: ;
      endcase
    end
    // read data valid in the cycle after the strobe only
    state_nxt.rdata = DCP_UNMAPPED;
    if (bus.rd) begin
      unique case (bus.addr)
        DCP_CLR_LO_OFS: state_nxt.rdata = state_r.clr_lo;
        DCP_CLR_HI_OFS: state_nxt.rdata = state_r.clr_hi;
        DCP_PWR_LO_OFS: state_nxt.rdata = state_r.pwr_lo;
        DCP_PWR_HI_OFS: state_nxt.rdata = state_r.pwr_hi;
        default:        state_nxt.rdata = DCP_UNMAPPED;
      endcase
    end
    // outputs follow stored bits one cycle later
    state_nxt.clear_out  = {state_r.clr_hi, state_r.clr_lo};
    state_nxt.active_out = {state_r.pwr_hi, state_r.pwr_lo};
    state_nxt.clamp_out  = ~{state_r.pwr_hi, state_r.pwr_lo};
  end

  //------------------------------------------------------------
  // state register
  //------------------------------------------------------------
  // synchronous reset: everything off and clamped
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r            <= '0;
      state_r.clr_lo     <= DCP_REG_RST;
      state_r.clr_hi     <= DCP_REG_RST;
      state_r.pwr_lo     <= DCP_REG_RST;
      state_r.pwr_hi     <= DCP_REG_RST;
      state_r.clamp_out  <= DCP_CLAMP_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata      = state_r.rdata;
  assign dac_clear  = state_r.clear_out;
  assign dac_active = state_r.active_out;
  assign dac_clamp  = state_r.clamp_out;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  a_clear_follow: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_LO_OFS) |-> ##2 dac_clear[7:0] == $past(bus.wdata, 2))
    else $error("low clear outputs do not follow write");
  a_clear_release: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_HI_OFS && bus.wdata == 8'h00) |-> ##2 dac_clear[15:8] == 8'h00)
    else $error("cleared channels not released");
  a_clear_hi_map: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_HI_OFS) |-> ##2 dac_clear[15:8] == $past(bus.wdata, 2))
    else $error("high clear outputs do not follow write");
  a_reset_off: assert property (@(posedge clk)
    rst |=> (dac_active == 16'h0000 && dac_clamp == DCP_CLAMP_RST))
    else $error("channels not off after reset");
  a_clamp_inverse: assert property (@(posedge clk) disable iff (rst)
    ##1 dac_clamp == ~dac_active)
    else $error("clamp is not inverse of active");
  a_power_on: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_LO_OFS && bus.wdata[0]) |-> ##2 dac_active[0])
    else $error("channel zero not activated");
  a_power_lo_map: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_LO_OFS) |-> ##2 dac_active[7:0] == $past(bus.wdata, 2))
    else $error("low power outputs do not follow write");
  a_power_hi_map: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_HI_OFS) |-> ##2 dac_active[15:8] == $past(bus.wdata, 2))
    else $error("high power outputs do not follow write");
  a_readback: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_HI_OFS) ##1 (bus.rd && bus.addr == DCP_PWR_HI_OFS)
    |-> ##1 rdata == $past(bus.wdata, 2))
    else $error("readback differs from written value");

  //------------------------------------------------------------
  // checker helpers
  //------------------------------------------------------------
  // stored bits gathered per channel, low register first
  logic [15:0] clr_bits;
  logic [15:0] pwr_bits;
  logic        addr_mapped;

  assign clr_bits    = {state_r.clr_hi, state_r.clr_lo};
  assign pwr_bits    = {state_r.pwr_hi, state_r.pwr_lo};
  assign addr_mapped = (bus.addr >= DCP_CLR_LO_OFS) && (bus.addr <= DCP_PWR_HI_OFS);

  //------------------------------------------------------------
  // per-channel checks
  //------------------------------------------------------------
  // each clear and active output follows its own stored bit one cycle later; each clamp output is the inverse of its active output
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    a_chan_clear: assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> dac_clear[ch] == $past(clr_bits[ch]))
      else $error("channel clear output differs from stored bit");
    a_chan_active: assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> dac_active[ch] == $past(pwr_bits[ch]))
      else $error("channel active output differs from stored bit");
    a_chan_clamp: assert property (@(posedge clk) disable iff (rst)
      dac_clamp[ch] == !dac_active[ch])
      else $error("channel clamp equals channel active");
  end

  //------------------------------------------------------------
  // register bank checks
  //------------------------------------------------------------
  // write to low clear register lands at the strobe edge
  a_wr_clr_lo: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_LO_OFS)
    |=> state_r.clr_lo == $past(bus.wdata))
    else $error("low clear register missed write");

  // write to high clear register lands at the strobe edge
  a_wr_clr_hi: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_HI_OFS)
    |=> state_r.clr_hi == $past(bus.wdata))
    else $error("high clear register missed write");

  // write to low power register lands at the strobe edge
  a_wr_pwr_lo: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_LO_OFS)
    |=> state_r.pwr_lo == $past(bus.wdata))
    else $error("low power register missed write");

  // write to high power register lands at the strobe edge
  a_wr_pwr_hi: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_HI_OFS)
    |=> state_r.pwr_hi == $past(bus.wdata))
    else $error("high power register missed write");

  // low clear write leaves the other registers alone
  a_iso_clr_lo: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_LO_OFS)
    |=> $stable(state_r.clr_hi) && $stable(pwr_bits))
    else $error("low clear write disturbed another register");

  // high clear write leaves the other registers alone
  a_iso_clr_hi: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_HI_OFS)
    |=> $stable(state_r.clr_lo) && $stable(pwr_bits))
    else $error("high clear write disturbed another register");

  // low power write leaves the other registers alone
  a_iso_pwr_lo: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_LO_OFS)
    |=> $stable(state_r.pwr_hi) && $stable(clr_bits))
    else $error("low power write disturbed another register");

  // high power write leaves the other registers alone
  a_iso_pwr_hi: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_HI_OFS)
    |=> $stable(state_r.pwr_lo) && $stable(clr_bits))
    else $error("high power write disturbed another register");

  // clear bits hold while no write is made
  a_hold_clr: assert property (@(posedge clk) disable iff (rst)
    !bus.wr
    |=> $stable(clr_bits))
    else $error("clear bits changed without a write");

  // power bits hold while no write is made
  a_hold_pwr: assert property (@(posedge clk) disable iff (rst)
    !bus.wr
    |=> $stable(pwr_bits))
    else $error("power bits changed without a write");

  // writes outside the bank change nothing
  a_unmapped_wr: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && !addr_mapped)
    |=> $stable(clr_bits) && $stable(pwr_bits))
    else $error("unmapped write changed a register");

  // read of low clear register returns stored byte
  a_rd_clr_lo: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == DCP_CLR_LO_OFS)
    |=> rdata == $past(state_r.clr_lo))
    else $error("low clear readback wrong");

  // read of high clear register returns stored byte
  a_rd_clr_hi: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == DCP_CLR_HI_OFS)
    |=> rdata == $past(state_r.clr_hi))
    else $error("high clear readback wrong");

  // read of low power register returns stored byte
  a_rd_pwr_lo: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == DCP_PWR_LO_OFS)
    |=> rdata == $past(state_r.pwr_lo))
    else $error("low power readback wrong");

  // read of high power register returns stored byte
  a_rd_pwr_hi: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == DCP_PWR_HI_OFS)
    |=> rdata == $past(state_r.pwr_hi))
    else $error("high power readback wrong");

  // reads outside the bank return zero
  a_rd_unmapped: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && !addr_mapped)
    |=> rdata == DCP_UNMAPPED)
    else $error("unmapped read not zero");

  // read data stands only in the cycle after the strobe
  a_rd_idle: assert property (@(posedge clk) disable iff (rst)
    !bus.rd
    |=> rdata == DCP_UNMAPPED)
    else $error("read data present without a read");

  // reads never change stored bits
  a_rd_no_side: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && !bus.wr)
    |=> $stable(clr_bits) && $stable(pwr_bits))
    else $error("read changed a register");

  // reset zeroes all power bits
  a_rst_pwr: assert property (@(posedge clk)
    rst
    |=> pwr_bits == 16'h0000)
    else $error("power bits not zero after reset");

  // reset zeroes all clear bits
  a_rst_clr: assert property (@(posedge clk)
    rst
    |=> clr_bits == 16'h0000)
    else $error("clear bits not zero after reset");

  // reset releases every clear output
  a_rst_clear_out: assert property (@(posedge clk)
    rst
    |=> dac_clear == 16'h0000)
    else $error("clear outputs not released by reset");

  // reset clamps every channel
  a_rst_clamp: assert property (@(posedge clk)
    rst
    |=> dac_clamp == DCP_CLAMP_RST)
    else $error("channels not clamped after reset");

  // reset drops read data
  a_rst_rdata: assert property (@(posedge clk)
    rst
    |=> rdata == DCP_UNMAPPED)
    else $error("read data not zero after reset");

  // low clear write read back in the very next cycle
  a_wr_rd_lo: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_LO_OFS) ##1 (bus.rd && bus.addr == DCP_CLR_LO_OFS)
    |=> rdata == $past(bus.wdata, 2))
    else $error("back to back readback of low clear wrong");

  // top bit of low clear forces channel seven
  a_clear_set_one: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_LO_OFS && bus.wdata[7])
    |-> ##2 dac_clear[7])
    else $error("channel seven not forced clear");

  // bit six of high clear forces channel fourteen
  a_clear_hi_one: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_HI_OFS && bus.wdata[6])
    |-> ##2 dac_clear[14])
    else $error("channel fourteen not forced clear");

  // zero to low clear returns channels to normal
  a_clear_zero: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_CLR_LO_OFS && bus.wdata == 8'h00)
    |-> ##2 dac_clear[7:0] == 8'h00)
    else $error("low channels not released from clear");

  // zero power bit keeps channel zero clamped
  a_power_off: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_LO_OFS && !bus.wdata[0])
    |-> ##2 (dac_clamp[0] && !dac_active[0]))
    else $error("channel zero not clamped");

  // top bit of high power activates channel fifteen
  a_power_hi_on: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_HI_OFS && bus.wdata[7])
    |-> ##2 (dac_active[15] && !dac_clamp[15]))
    else $error("channel fifteen not activated");

  // zero bit five of high power clamps channel thirteen
  a_power_hi_off: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == DCP_PWR_HI_OFS && !bus.wdata[5])
    |-> ##2 (dac_clamp[13] && !dac_active[13]))
    else $error("channel thirteen not clamped");

  // clear writes leave power bits alone
  a_clear_indep: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && (bus.addr == DCP_CLR_LO_OFS || bus.addr == DCP_CLR_HI_OFS))
    |=> $stable(pwr_bits))
    else $error("clear write changed power bits");

  // power writes leave clear bits alone
  a_power_indep: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && (bus.addr == DCP_PWR_LO_OFS || bus.addr == DCP_PWR_HI_OFS))
    |=> $stable(clr_bits))
    else $error("power write changed clear bits");

  // clear outputs stay put while stored bits do
  a_clear_steady: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && $stable(clr_bits))
    |=> $stable(dac_clear))
    else $error("clear outputs moved without a write");

  // active outputs stay put while stored bits do
  a_active_steady: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && $stable(pwr_bits))
    |=> $stable(dac_active))
    else $error("active outputs moved without a write");

endmodule

//--- dcp_pkg.sv
//------------------------------------------------------------
// clear and power-down register bank constants
//------------------------------------------------------------
package dcp_pkg;

  //------------------------------------------------------------
  // register map
  //------------------------------------------------------------
  localparam logic [7:0] DCP_CLR_LO_OFS = 8'hb0;
  localparam logic [7:0] DCP_CLR_HI_OFS = 8'hb1;
  localparam logic [7:0] DCP_PWR_LO_OFS = 8'hb2;
  localparam logic [7:0] DCP_PWR_HI_OFS = 8'hb3;
  localparam logic [7:0] DCP_REG_RST    = 8'h00;
  localparam logic [7:0] DCP_UNMAPPED   = 8'h00;
  localparam logic [15:0] DCP_CLAMP_RST = 16'hffff; // every channel clamped after reset

  //------------------------------------------------------------
  // carriers
  //------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dcp_bus_s;

  typedef struct packed {
    logic [7:0] clr_lo;
    logic [7:0] clr_hi;
    logic [7:0] pwr_lo;
    logic [7:0] pwr_hi;
    logic [7:0] rdata;
    logic [15:0] clear_out;
    logic [15:0] active_out;
    logic [15:0] clamp_out;
  } dcp_state_s;

endpackage

//--- dcp_regs_tb.sv
`timescale 1ns/1ps
module dcp_regs_tb
  import dcp_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  dcp_bus_s    bus = '0;
  logic [7:0]  rdata;
  logic [15:0] dac_clear;
  logic [15:0] dac_active;
  logic [15:0] dac_clamp;
  int          bad_count = 0;
  int          checked = 0;
  logic [7:0]  pat [4] = '{8'h81, 8'h5a, 8'h3c, 8'hc3};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  dcp_regs #(.CHANNELS(16)) u_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .dac_clear(dac_clear), .dac_active(dac_active), .dac_clamp(dac_clamp));

  //------------------------------------------------------------
  // bus and check tasks
  //------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // write then read the same register in the next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, d});
  endtask

  // read data sampled in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask

  // outputs lag the register by one cycle
  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  //------------------------------------------------------------
  // test sequence
  //------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdchk(DCP_CLR_LO_OFS + 8'(i), 8'h00);
    chk(dac_active, 16'h0000);
    chk(dac_clamp, 16'hffff);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) wr(DCP_CLR_LO_OFS + 8'(i), pat[i]);
    wr(8'hb4, 8'hff);
    settle();
    chk(dac_clear, 16'h5a81);
    chk(dac_active, 16'hc33c);
    chk(dac_clamp, 16'h3cc3);
    for (int i = 0; i < 4; i++) rdchk(DCP_CLR_LO_OFS + 8'(i), pat[i]);
    rdchk(8'hb4, 8'h00);
    $display("test write map done");
    wr(DCP_CLR_LO_OFS, 8'h00);
    wr(DCP_CLR_HI_OFS, 8'h00);
    settle();
    chk(dac_clear, 16'h0000);
    chk(dac_active, 16'hc33c);
    $display("test clear release done");
    wr_rd(DCP_PWR_HI_OFS, 8'hc3);
    wr_rd(DCP_CLR_LO_OFS, 8'h80);
    settle();
    chk({8'h00, rdata}, 16'h0000);
    wr(DCP_PWR_LO_OFS, 8'h01);
    settle();
    chk(dac_active, 16'hc301);
    chk(dac_clamp, 16'h3cfe);
    chk(dac_clear, 16'h0080);
    $display("test back to back done");
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1 chk(dac_active, 16'h0000);
    chk(dac_clamp, 16'hffff);
    chk(dac_clear, 16'h0000);
    for (int i = 0; i < 4; i++) rdchk(DCP_CLR_LO_OFS + 8'(i), 8'h00);
    $display("test mid-run reset done");
    tally_and_finish();
  end

  // hang guard
  initial begin
    #100us bad_count++;
    tally_and_finish();
  end
endmodule
